// >>> core/vvcfg_defines.svh
// Register offsets, field positions, reset values and scale figures
// for the VBUS, VCONN and pin configuration register group.
// Assumes an 8-bit register address and 8-bit register data.
`ifndef VVCFG_DEFINES_SVH
`define VVCFG_DEFINES_SVH

// ==========================================================
// Register offsets
`define VVCFG_STOP_DISCH_LO_ADDR  8'h74
`define VVCFG_STOP_DISCH_HI_ADDR  8'h75
`define VVCFG_ALARM_HI_LO_ADDR    8'h76
`define VVCFG_ALARM_HI_HI_ADDR    8'h77
`define VVCFG_ALARM_LO_LO_ADDR    8'h78
`define VVCFG_ALARM_LO_HI_ADDR    8'h79
`define VVCFG_VCONN_LIMIT_ADDR    8'hA0
`define VVCFG_SOFT_RESET_ADDR     8'hA2
`define VVCFG_PIN1_CFG_ADDR       8'hA4
`define VVCFG_PIN2_CFG_ADDR       8'hA5
`define VVCFG_PIN_STATUS_ADDR     8'hA6

// ==========================================================
// Reset values
`define VVCFG_STOP_DISCH_LO_RST   8'h1C
`define VVCFG_ZERO_RST            8'h00
`define VVCFG_VCONN_LIMIT_RST     4'hF

// ==========================================================
// Field positions and widths
`define VVCFG_HI_BYTE_BITS        2
`define VVCFG_RANGE_BIT           3
`define VVCFG_LEVEL_MSB           2
`define VVCFG_PD_RESET_BIT        1
`define VVCFG_ALL_RESET_BIT       0
`define VVCFG_OUT_VALUE_BIT       2
`define VVCFG_IN_ENABLE_BIT       1
`define VVCFG_OUT_ENABLE_BIT      0

// ==========================================================
// Scales: one threshold step in mV, range maxima in mA, level steps per range
`define VVCFG_VBUS_STEP_MV        50
`define VVCFG_LOW_RANGE_MAX_MA    10'h050
`define VVCFG_HIGH_RANGE_MAX_MA   10'h320
`define VVCFG_LEVEL_STEPS         8

`endif

// >>> core/vvcfg_pkg.sv
// Types shared by the VBUS, VCONN and pin configuration registers.
// Assumes the constants of vvcfg_defines.svh are included alongside.
package vvcfg_pkg;

  // ==========================================================
  // Configuration of one general-purpose pin
  typedef struct packed {
    logic out_value;
    logic in_enable;
    logic out_enable;
  } vvcfg_pin_cfg_t;

  // ==========================================================
  // Outcome of the VBUS comparisons
  typedef struct packed {
    logic above_high_alarm;
    logic below_low_alarm;
    logic below_stop_discharge;
  } vvcfg_vbus_flags_t;

  // ==========================================================
  // Drive of a two-way pin
  typedef struct packed {
    logic value;
    logic enable;
  } vvcfg_pin_drive_t;

endpackage : vvcfg_pkg

// >>> core/vvcfg_regs.sv
// VBUS threshold, VCONN current limit, soft reset and pin configuration
// registers with the logic that uses them.
// Assumes the device's serial engine turns host accesses into one-cycle
// read and write strobes on the clock, and that the VBUS ADC result and
// the VCONN enable come from logic on the same clock.
`timescale 1ns/1ps
`include "vvcfg_defines.svh"

module vvcfg_regs #(
  parameter int VBUS_BITS = 10
) (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  // Register access from the serial engine
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [7:0]                 reg_rdata,
  output logic                            reg_rvalid,
  // VBUS monitor
  input  wire logic [VBUS_BITS-1:0]       vbus_measure,
  output vvcfg_pkg::vvcfg_vbus_flags_t    vbus_flags,
  output logic      [VBUS_BITS-1:0]       vbus_upper_threshold,
  output logic      [VBUS_BITS-1:0]       vbus_lower_threshold,
  output logic      [VBUS_BITS-1:0]       vbus_stop_threshold,
  // VCONN over-current
  input  wire logic                       vconn_switch_enable,
  output logic                            vconn_limit_active,
  output logic      [9:0]                 vconn_limit_ma,
  // Soft resets
  output logic                            pd_logic_reset,
  // Fast role swap control of pin 2
  input  wire logic                       role_swap_pin_function,
  input  wire logic                       swap_out_value,
  input  wire logic                       swap_out_enable,
  output logic                            pin2_level_sync,
  // General-purpose pins
  input  wire logic                       pin1_in,
  output logic                            pin1_out,
  output logic                            pin1_oe,
  input  wire logic                       pin2_in,
  output logic                            pin2_out,
  output logic                            pin2_oe
);

  // ==========================================================
  // Helper functions

  // Join a threshold pair into one value
  function automatic logic [VBUS_BITS-1:0] join_pair(input logic [7:0] lo,
                                                     input logic [1:0] hi);
    join_pair = {hi, lo};
  endfunction

  // Drop bit 0 so that comparisons run on 100 mV granularity
  function automatic logic [VBUS_BITS-2:0] drop_lsb(input logic [VBUS_BITS-1:0] v);
    drop_lsb = v[VBUS_BITS-1:1];
  endfunction

  // ==========================================================
  // Register storage
  logic [7:0] stop_lo_q;
  logic [1:0] stop_hi_q;
  logic [7:0] alarm_hi_lo_q;
  logic [1:0] alarm_hi_hi_q;
  logic [7:0] alarm_lo_lo_q;
  logic [1:0] alarm_lo_hi_q;
  logic [3:0] vconn_limit_q;
  logic [1:0] soft_reset_q;
  vvcfg_pkg::vvcfg_pin_cfg_t pin1_cfg_q;
  vvcfg_pkg::vvcfg_pin_cfg_t pin2_cfg_q;
  logic [1:0] pin_status_q;

  // ==========================================================
  // Address decode
  wire wr_stop_lo     = reg_wr && (reg_addr == `VVCFG_STOP_DISCH_LO_ADDR);
  wire wr_stop_hi     = reg_wr && (reg_addr == `VVCFG_STOP_DISCH_HI_ADDR);
  wire wr_alarm_hi_lo = reg_wr && (reg_addr == `VVCFG_ALARM_HI_LO_ADDR);
  wire wr_alarm_hi_hi = reg_wr && (reg_addr == `VVCFG_ALARM_HI_HI_ADDR);
  wire wr_alarm_lo_lo = reg_wr && (reg_addr == `VVCFG_ALARM_LO_LO_ADDR);
  wire wr_alarm_lo_hi = reg_wr && (reg_addr == `VVCFG_ALARM_LO_HI_ADDR);
  wire wr_vconn       = reg_wr && (reg_addr == `VVCFG_VCONN_LIMIT_ADDR);
  wire wr_soft_reset  = reg_wr && (reg_addr == `VVCFG_SOFT_RESET_ADDR);
  wire wr_pin1        = reg_wr && (reg_addr == `VVCFG_PIN1_CFG_ADDR);
  wire wr_pin2        = reg_wr && (reg_addr == `VVCFG_PIN2_CFG_ADDR);

  // A pending all-register request wipes every writable register one cycle later
  wire all_reset_req  = soft_reset_q[`VVCFG_ALL_RESET_BIT];

  // ==========================================================
  // Threshold registers
  // Stop pair reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stop_lo_q     <= `VVCFG_STOP_DISCH_LO_RST;
      stop_hi_q     <= 2'h0;
      alarm_hi_lo_q <= `VVCFG_ZERO_RST;
      alarm_hi_hi_q <= 2'h0;
      alarm_lo_lo_q <= `VVCFG_ZERO_RST;
      alarm_lo_hi_q <= 2'h0;
    end else if (all_reset_req) begin
      stop_lo_q     <= `VVCFG_STOP_DISCH_LO_RST;
      stop_hi_q     <= 2'h0;
      alarm_hi_lo_q <= `VVCFG_ZERO_RST;
      alarm_hi_hi_q <= 2'h0;
      alarm_lo_lo_q <= `VVCFG_ZERO_RST;
      alarm_lo_hi_q <= 2'h0;
    end else begin
      if (wr_stop_lo)     stop_lo_q     <= reg_wdata;
      if (wr_stop_hi)     stop_hi_q     <= reg_wdata[`VVCFG_HI_BYTE_BITS-1:0];
      if (wr_alarm_hi_lo) alarm_hi_lo_q <= reg_wdata;
      if (wr_alarm_hi_hi) alarm_hi_hi_q <= reg_wdata[`VVCFG_HI_BYTE_BITS-1:0];
      if (wr_alarm_lo_lo) alarm_lo_lo_q <= reg_wdata;
      if (wr_alarm_lo_hi) alarm_lo_hi_q <= reg_wdata[`VVCFG_HI_BYTE_BITS-1:0];
    end
  end

  // ==========================================================
  // VCONN limit and pin configuration registers
  // Level resets to full range
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vconn_limit_q <= `VVCFG_VCONN_LIMIT_RST;
      pin1_cfg_q    <= '0;
      pin2_cfg_q    <= '0;
    end else if (all_reset_req) begin
      vconn_limit_q <= `VVCFG_VCONN_LIMIT_RST;
      pin1_cfg_q    <= '0;
      pin2_cfg_q    <= '0;
    end else begin
      if (wr_vconn) vconn_limit_q <= reg_wdata[3:0];
      if (wr_pin1)  pin1_cfg_q    <= reg_wdata[2:0];
      if (wr_pin2)  pin2_cfg_q    <= reg_wdata[2:0];
    end
  end

  // ==========================================================
  // Soft reset requests
  // One starts PD reset
  // Bits clear themselves
  // Writing zero leaves nothing pending; a request lives one cycle only.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_q <= 2'h0;
    end else if (wr_soft_reset && !all_reset_req) begin
      soft_reset_q <= reg_wdata[1:0];
    end else begin
      soft_reset_q <= 2'h0;
    end
  end

  assign pd_logic_reset = soft_reset_q[`VVCFG_PD_RESET_BIT];

  // ==========================================================
  // VBUS comparisons
  // Compare against thresholds
  assign vbus_upper_threshold = join_pair(alarm_hi_lo_q, alarm_hi_hi_q);
  assign vbus_lower_threshold = join_pair(alarm_lo_lo_q, alarm_lo_hi_q);
  assign vbus_stop_threshold  = join_pair(stop_lo_q, stop_hi_q);

  wire above_hi = drop_lsb(vbus_measure) > drop_lsb(vbus_upper_threshold);
  wire below_lo = drop_lsb(vbus_measure) < drop_lsb(vbus_lower_threshold);
  wire below_sd = drop_lsb(vbus_measure) < drop_lsb(vbus_stop_threshold);

  // Registered so the flags are glitch free toward the alarm logic
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vbus_flags <= '0;
    end else begin
      vbus_flags <= '{above_high_alarm: above_hi,
                      below_low_alarm: below_lo,
                      below_stop_discharge: below_sd};
    end
  end

  // ==========================================================
  // VCONN current limit in mA
  // Range selects maximum
  wire [9:0] range_max_ma = vconn_limit_q[`VVCFG_RANGE_BIT] ?
                            `VVCFG_HIGH_RANGE_MAX_MA : `VVCFG_LOW_RANGE_MAX_MA;
  wire [9:0] step_ma      = range_max_ma / 10'(`VVCFG_LEVEL_STEPS);
  wire [3:0] level_count  = {1'b0, vconn_limit_q[`VVCFG_LEVEL_MSB:0]} + 4'h1;
  wire [13:0] limit_prod  = step_ma * level_count;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vconn_limit_active <= 1'b0;
      vconn_limit_ma     <= 10'h000;
    end else begin
      vconn_limit_active <= vconn_switch_enable;
      vconn_limit_ma     <= vconn_switch_enable ? limit_prod[9:0] : 10'h000;
    end
  end

  // ==========================================================
  // Pin input synchronisers; the first stage feeds only the second
  logic [1:0] pin1_meta_q;
  logic [1:0] pin1_sync_q;
  logic       pin2_sync_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin1_meta_q <= 2'h0;
      pin1_sync_q <= 2'h0;
    end else begin
      pin1_meta_q <= {pin2_in, pin1_in};
      pin1_sync_q <= pin1_meta_q;
    end
  end

  // Pin 2 shares the two-stage vector above; this alias names its output.
  // The swap logic sees the level even while the input buffer is off.
  assign pin2_sync_q     = pin1_sync_q[1];
  assign pin2_level_sync = pin2_sync_q;

  // ==========================================================
  // Pin drive
  // Swap function takes pin 2
  wire generic_pin2 = !role_swap_pin_function;

  assign pin1_oe  = pin1_cfg_q.out_enable;
  assign pin1_out = pin1_cfg_q.out_value;
  assign pin2_oe  = generic_pin2 ? pin2_cfg_q.out_enable : swap_out_enable;
  assign pin2_out = generic_pin2 ? pin2_cfg_q.out_value : swap_out_value;

  // ==========================================================
  // Pin status
  // Input buffer enable gates level
  // Bit 0 pin 1, bit 1 pin 2
  wire pin1_seen = pin1_cfg_q.in_enable && pin1_sync_q[0];
  wire pin2_seen = generic_pin2 && pin2_cfg_q.in_enable && pin2_sync_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_status_q <= 2'h0;
    end else begin
      pin_status_q <= {pin2_seen, pin1_seen};
    end
  end

  // ==========================================================
  // Read mux; unmapped offsets read zero
  // Upper bits read zero
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      `VVCFG_STOP_DISCH_LO_ADDR: rd_mux = stop_lo_q;
      `VVCFG_STOP_DISCH_HI_ADDR: rd_mux = {6'h00, stop_hi_q};
      `VVCFG_ALARM_HI_LO_ADDR:   rd_mux = alarm_hi_lo_q;
      `VVCFG_ALARM_HI_HI_ADDR:   rd_mux = {6'h00, alarm_hi_hi_q};
      `VVCFG_ALARM_LO_LO_ADDR:   rd_mux = alarm_lo_lo_q;
      `VVCFG_ALARM_LO_HI_ADDR:   rd_mux = {6'h00, alarm_lo_hi_q};
      `VVCFG_VCONN_LIMIT_ADDR:   rd_mux = {4'h0, vconn_limit_q};
      `VVCFG_SOFT_RESET_ADDR:    rd_mux = {6'h00, soft_reset_q};
      `VVCFG_PIN1_CFG_ADDR:      rd_mux = {5'h00, pin1_cfg_q};
      `VVCFG_PIN2_CFG_ADDR:      rd_mux = {5'h00, pin2_cfg_q};
      `VVCFG_PIN_STATUS_ADDR:    rd_mux = {6'h00, pin_status_q};
      default:                   rd_mux = 8'h00;
    endcase
  end

  // Read data registered one cycle after the strobe
  // Data holds between reads, so a slow host may pick it up late
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rd_mux;
    end
  end

endmodule // vvcfg_regs

// >>> sim/vvcfg_host_model.sv
// Host-side model: turns bench calls into register strobes.
// Assumes one-cycle strobes, changed only on the falling clock edge.
`timescale 1ns/1ps
module vvcfg_host_model (
  input  wire logic       clock,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // ==========================================================
  // One access; address and data inverted after, so stale values never match
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = w;
    reg_rd    = ~w;
    @(negedge clock);
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic wr_pair(input logic [7:0] a, input logic [9:0] v);
    access(1'b1, a, v[7:0]);
    access(1'b1, a + 8'h01, {6'h00, v[9:8]});
  endtask
endmodule // vvcfg_host_model

// >>> sim/vvcfg_regs_asserts.sv
// Checker for the threshold, current limit, soft reset and pin registers.
// Assumes it is bound to vvcfg_regs and sees only its ports.
`timescale 1ns/1ps
module vvcfg_regs_asserts #(
  parameter int VBUS_BITS = 10
) (
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire logic [7:0]           reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic                 reg_rvalid,
  input wire logic [VBUS_BITS-1:0] vbus_measure,
  input vvcfg_pkg::vvcfg_vbus_flags_t vbus_flags,
  input wire logic [VBUS_BITS-1:0] vbus_upper_threshold,
  input wire logic [VBUS_BITS-1:0] vbus_lower_threshold,
  input wire logic [VBUS_BITS-1:0] vbus_stop_threshold,
  input wire logic                 vconn_switch_enable,
  input wire logic                 vconn_limit_active,
  input wire logic [9:0]           vconn_limit_ma,
  input wire logic                 pd_logic_reset,
  input wire logic                 role_swap_pin_function,
  input wire logic                 swap_out_value,
  input wire logic                 swap_out_enable,
  input wire logic                 pin1_out,
  input wire logic                 pin1_oe,
  input wire logic                 pin2_out,
  input wire logic                 pin2_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Register port answers
  a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  a_rvalid_pulse: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read valid");
  // ==========================================================
  // Threshold joining and comparisons on bits 9:1
  a_stop_join: assert property (reg_wr && reg_addr == 8'h74 |=>
    vbus_stop_threshold[7:0] == $past(reg_wdata)) else $error("stop low byte lost");
  a_upper_join: assert property (reg_wr && reg_addr == 8'h77 |=>
    vbus_upper_threshold[9:8] == $past(reg_wdata[1:0])) else $error("upper bits lost");
  a_high_alarm: assert property (1'b1 |=> vbus_flags.above_high_alarm ==
    ($past(vbus_measure[9:1]) > $past(vbus_upper_threshold[9:1]))) else $error("high alarm");
  a_low_alarm: assert property (1'b1 |=> vbus_flags.below_low_alarm ==
    ($past(vbus_measure[9:1]) < $past(vbus_lower_threshold[9:1]))) else $error("low alarm");
  a_stop_flag: assert property (1'b1 |=> vbus_flags.below_stop_discharge ==
    ($past(vbus_measure[9:1]) < $past(vbus_stop_threshold[9:1]))) else $error("stop flag");
  // ==========================================================
  // Limit, soft reset and pins
  a_vconn_off: assert property (!vconn_switch_enable |=>
    vconn_limit_ma == 10'h000 && !vconn_limit_active) else $error("limit while off");
  sequence pd_pulse;
    pd_logic_reset ##1 !pd_logic_reset;
  endsequence
  a_pd_pulse: assert property (reg_wr && reg_addr == 8'hA2 && reg_wdata[1] |=> pd_pulse)
    else $error("pd reset pulse wrong");
  a_pin1_drive: assert property (reg_wr && reg_addr == 8'hA4 |=>
    pin1_oe == $past(reg_wdata[0]) && (!pin1_oe || pin1_out == $past(reg_wdata[2])))
    else $error("pin1 drive wrong");
  a_pin2_swap: assert property (role_swap_pin_function |->
    pin2_oe == swap_out_enable && pin2_out == swap_out_value) else $error("pin2 swap drive");
endmodule // vvcfg_regs_asserts

bind vvcfg_regs vvcfg_regs_asserts #(.VBUS_BITS(VBUS_BITS)) u_vvcfg_regs_asserts (.*);

// >>> sim/vvcfg_regs_tb.sv
// Self-checking bench for the configuration registers.
// Assumes the host model drives the strobe port; bench drives the rest.
`timescale 1ns/1ps
module vvcfg_regs_tb;
  logic clock, rst_n, reg_wr, reg_rd, reg_rvalid, pd_logic_reset;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rnd;
  logic [9:0] vbus_measure, vbus_upper_threshold, vbus_lower_threshold, m;
  logic [9:0] vbus_stop_threshold, vconn_limit_ma, th [3];
  vvcfg_pkg::vvcfg_vbus_flags_t vbus_flags;
  logic vconn_switch_enable, vconn_limit_active, role_swap_pin_function;
  logic swap_out_value, swap_out_enable, pin2_level_sync;
  logic pin1_in, pin1_out, pin1_oe, pin2_in, pin2_out, pin2_oe;
  int num_errors = 0;
  int check_count = 0;
  integer seed = 32'h08E5;
  logic [7:0] exp_q [$];
  localparam logic [7:0] addr_tab [11] = '{8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79,
                                          8'hA0, 8'hA2, 8'hA4, 8'hA5, 8'h80};
  localparam logic [7:0] rst_tab [11] = '{8'h1C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                         8'h0F, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] mask_tab [11] = '{8'hFF, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'h03,
                                          8'h0F, 8'h00, 8'h07, 8'h07, 8'h00};

  vvcfg_regs u_vvcfg_regs (.*);
  vvcfg_host_model u_vvcfg_host_model (.*);

  // ==========================================================
  // Clock, checks and closing
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic cmp_val(input string n, input logic [9:0] e, input logic [9:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Read notes queued by the driver, matched when a result shows
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_vvcfg_host_model.access(1'b0, a, 8'h00);
  endtask
  always @(negedge clock) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) cmp_val("unexpected read", 10'h3FF, {2'h0, reg_rdata});
      else cmp_val("read data", {2'h0, exp_q.pop_front()}, {2'h0, reg_rdata});
    end
  end
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    num_errors++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    vbus_measure = 10'h000;
    vconn_switch_enable = 1'b0;
    role_swap_pin_function = 1'b0;
    swap_out_value = 1'b0;
    swap_out_enable = 1'b0;
    pin1_in = 1'b0;
    pin2_in = 1'b0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    foreach (addr_tab[i]) rd(addr_tab[i], rst_tab[i]);
    foreach (addr_tab[i]) if (addr_tab[i] != 8'hA2) begin
      rnd = 8'($random(seed));
      u_vvcfg_host_model.access(1'b1, addr_tab[i], rnd);
      rd(addr_tab[i], rnd & mask_tab[i]);
    end
    // Thresholds; first three measures sit on a threshold in all but bit 0
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 3; k++) begin
        th[k] = 10'($random(seed));
        u_vvcfg_host_model.wr_pair(8'h74 + 8'(2 * k), th[k]);
      end
      m = (i < 3) ? th[i] ^ 10'h001 : 10'($random(seed));
      vbus_measure = m;
      repeat (2) @(negedge clock);
      cmp_val("stop threshold", th[0], vbus_stop_threshold);
      cmp_val("upper threshold", th[1], vbus_upper_threshold);
      cmp_val("lower threshold", th[2], vbus_lower_threshold);
      cmp_val("flags", {7'h00, m[9:1] > th[1][9:1], m[9:1] < th[2][9:1],
                        m[9:1] < th[0][9:1]}, {7'h00, vbus_flags});
    end
    // Every range and level code; switch off for level code 3 in both ranges
    for (int r = 0; r < 2; r++) for (int c = 0; c < 8; c++) begin
      u_vvcfg_host_model.access(1'b1, 8'hA0, 8'(r * 8 + c));
      vconn_switch_enable = (c != 3);
      repeat (3) @(negedge clock);
      cmp_val("limit", (c == 3) ? 10'h000 : 10'((c + 1) * (r ? 100 : 10)), vconn_limit_ma);
      cmp_val("limit active", {9'h000, c != 3}, {9'h000, vconn_limit_active});
    end
    // Pins
    pin1_in = 1'b1;
    pin2_in = 1'b1;
    u_vvcfg_host_model.access(1'b1, 8'hA4, 8'h05);
    cmp_val("pin1 drive", 10'h003, {8'h00, pin1_oe, pin1_out});
    u_vvcfg_host_model.access(1'b1, 8'hA4, 8'h02);
    u_vvcfg_host_model.access(1'b1, 8'hA5, 8'h07);
    cmp_val("pin drive", 10'h003, {6'h00, pin1_oe, pin1_out, pin2_oe, pin2_out});
    repeat (4) @(negedge clock);
    rd(8'hA6, 8'h03);
    cmp_val("pin2 sync", 10'h001, {9'h000, pin2_level_sync});
    role_swap_pin_function = 1'b1;
    swap_out_enable = 1'b1;
    repeat (4) @(negedge clock);
    cmp_val("pin2 swap", 10'h002, {8'h00, pin2_oe, pin2_out});
    rd(8'hA6, 8'h01);
    // Soft resets: PD only, no-op, then all registers
    u_vvcfg_host_model.access(1'b1, 8'hA2, 8'h02);
    rd(8'hA2, 8'h00);
    u_vvcfg_host_model.access(1'b1, 8'hA2, 8'h00);
    rd(8'hA4, 8'h02);
    u_vvcfg_host_model.access(1'b1, 8'hA2, 8'h01);
    repeat (2) @(negedge clock);
    foreach (addr_tab[i]) rd(addr_tab[i], rst_tab[i]);
    rd(8'hA6, 8'h00);
    repeat (4) @(negedge clock);
    final_report();
  end
endmodule // vvcfg_regs_tb
